// ===== src/power_mode_consts.vh
// Constants for the power-mode controller: register offsets, fields, codes, timing.
// Assumes inclusion by bare name from the domain-map and controller files; definitions only.
//
// Contract
// - Wake from memory retention timers-on resets system
// - Register retention keeps registers, SRAM; crystal optional
// - Register retention timers-off wakes by pin only
// - Register retention timers-on wakes pin, tick, comparator
// - Register retention wake resumes, never resets
// - Tick wake uses short pre-start when crystal idle
// - No short pre-start unless crystal ran before
// - Standby stops processor clock, keeps memories powered
// - Standby adds radio, misc wakes; no comparator
// - Code 100 picks timers-on by active slow source
// - Active keeps all domains powered, processor running
// - Codes 001..100 select power-saving modes; codes 101..111 are ignored
// - Wake-cause flags bits 7..5, cleared by read/entry
// - Pin wake from deep sleep, memory-off resets
`ifndef POWER_MODE_CONSTS_VH
`define POWER_MODE_CONSTS_VH

// Register byte offsets
`define PMC_ADDR_POWER_DOWN 8'h00
`define PMC_ADDR_SYS_CLK 8'h04
`define PMC_ADDR_SLOW_CLK 8'h08
`define PMC_ADDR_IRQ_STATUS 8'h0C
`define PMC_ADDR_IRQ_CLEAR 8'h10
`define PMC_ADDR_IRQ_ENABLE 8'h14
`define PMC_ADDR_MODE 8'h18
`define PMC_ADDR_STANDBY 8'h1C

// Reset values
`define PMC_SYS_CLK_RESET 8'h00
`define PMC_SLOW_CLK_RESET 3'h7

// Field positions
`define PMC_FLAG_PIN_BIT 7
`define PMC_FLAG_TICK_BIT 6
`define PMC_FLAG_COMP_BIT 5
`define PMC_KEEP_XTAL_BIT 7
`define PMC_START_SEL_HI 5
`define PMC_START_SEL_LO 4
`define PMC_XTAL_RUN_BIT 3

// Power-down mode codes
`define PMC_PD_NONE 3'h0
`define PMC_PD_DEEP 3'h1
`define PMC_PD_MEM_OFF 3'h2
`define PMC_PD_MEM_ON 3'h3
`define PMC_PD_REG 3'h4

// Start-select codes; 01 runs only the RC oscillator
`define PMC_START_RC_ONLY 2'h1
// Slow sources 000..100 are active, 101..111 are not
`define PMC_SLOW_LAST_ACTIVE 3'h4

// Wake vector bit positions
`define PMC_WAKE_PIN 0
`define PMC_WAKE_TICK 1
`define PMC_WAKE_COMP 2
`define PMC_WAKE_RADIO 3
`define PMC_WAKE_MISC 4
`define PMC_WAKE_W 5

// Domain enable vector: pins, pmgr+iram, slow osc, regs+sram, xtal, mem, voltage_regulator, io
`define PMC_DOM_W 8
`define PMC_XTAL_DOM_BIT 4

// Controller states
`define PMC_ST_ACTIVE 3'h0
`define PMC_ST_DEEP 3'h1
`define PMC_ST_MEM_OFF 3'h2
`define PMC_ST_MEM_ON 3'h3
`define PMC_ST_REG_OFF 3'h4
`define PMC_ST_REG_ON 3'h5
`define PMC_ST_STANDBY 3'h6
`define PMC_ST_WAKE 3'h7

// Timing
`define PMC_CLOCK_MHZ 200
`define PMC_LONG_PRESTART_US 100
`define PMC_STANDBY_WAKE_NS 100
`define PMC_SHORT_PRESTART_CYCLES 4
`define PMC_CNT_W 16

`endif

// ===== src/sync_two_flop.v
// Two-flop synchroniser for asynchronous level inputs.
// Assumes one clock and an already synchronised active-low reset.
`timescale 1ns/1ps
module sync_two_flop #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // Data
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1 <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule

// ===== src/power_domain_map.v
// Per-state map of powered domains and permitted wake sources.
// Assumes state codes from the constants header; purely combinational.
`timescale 1ns/1ps
`include "power_mode_consts.vh"
module power_domain_map (
  // Inputs
  input wire [2:0] i_state,
  input wire i_keep_xtal,
  // Outputs
  output reg [`PMC_DOM_W-1:0] o_domains,
  output reg [`PMC_WAKE_W-1:0] o_allowed
);
  always @* begin
    o_domains = 8'hFF;
    o_allowed = 5'h00;
    case (i_state)
      `PMC_ST_ACTIVE: begin
        o_domains = 8'hFF;
      end
      `PMC_ST_DEEP: begin
        o_domains = 8'h01;
        o_allowed = 5'h01;
      end
      `PMC_ST_MEM_OFF: begin
        o_domains = 8'h03;
        o_allowed = 5'h01;
      end
      `PMC_ST_MEM_ON: begin
        o_domains = 8'h07;
        o_allowed = 5'h07;
      end
      `PMC_ST_REG_OFF: begin
        o_domains = {3'h0, i_keep_xtal, 4'hF};
        o_allowed = 5'h01;
      end
      `PMC_ST_REG_ON: begin
        o_domains = {3'h0, i_keep_xtal, 4'hF};
        o_allowed = 5'h07;
      end
      `PMC_ST_STANDBY: begin
        o_domains = 8'hFF;
        o_allowed = 5'h1B;
      end
      `PMC_ST_WAKE: begin
        o_domains = 8'hFF;
      end
      default: begin
        o_domains = 8'hFF;
      end
    endcase
  end
endmodule

// ===== src/power_mode_controller.v
// Power-mode controller: APB registers, mode entry, wake gating, pre-start and resume.
// Assumes one 200 MHz clock, an APB master, asynchronous wake pins and crystal status.
`timescale 1ns/1ps
`include "power_mode_consts.vh"
module power_mode_controller #(
  parameter [`PMC_CNT_W-1:0] LONG_PRESTART_CYCLES = `PMC_LONG_PRESTART_US * `PMC_CLOCK_MHZ,
  parameter [`PMC_CNT_W-1:0] SHORT_PRESTART_CYCLES = `PMC_SHORT_PRESTART_CYCLES,
  parameter [`PMC_CNT_W-1:0] STANDBY_WAKE_CYCLES = (`PMC_STANDBY_WAKE_NS * `PMC_CLOCK_MHZ) / 1000
) (
  // Clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // Wake sources
  input wire i_wake_pin,
  input wire i_wake_tick,
  input wire i_wake_comp,
  input wire i_radio_interrupt,
  input wire i_misc_interrupt,
  // Oscillator status
  input wire i_fast_crystal_running,
  // Power and execution control
  output reg [`PMC_DOM_W-1:0] o_domain_power,
  output reg o_cpu_clock_en,
  output reg o_cpu_resume,
  output reg o_system_reset,
  output reg o_short_prestart,
  output reg o_irq
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  reg rst_meta_n;
  reg rst_n;

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  wire [3:0] async_sync;
  wire [`PMC_WAKE_W-1:0] wake_vec;
  wire xtal_running;

  sync_two_flop #(
    .WIDTH(4)
  ) u_sync (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_async({i_fast_crystal_running, i_wake_comp, i_wake_tick, i_wake_pin}),
    .o_sync(async_sync)
  );

  // Radio and misc interrupts are on this clock already
  assign wake_vec = {i_misc_interrupt, i_radio_interrupt, async_sync[2:0]};
  assign xtal_running = async_sync[3];

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg [2:0] state;
  reg [7:0] sys_clk_ctrl;
  reg [2:0] slow_src;
  reg [2:0] wake_flags;
  reg [3:0] irq_status;
  reg [3:0] irq_enable;
  reg xtal_at_entry;
  reg reset_on_wake;
  reg [`PMC_CNT_W-1:0] wake_count;

  wire [`PMC_DOM_W-1:0] domains;
  wire [`PMC_WAKE_W-1:0] allowed;

  power_domain_map u_map (
    .i_state(state),
    .i_keep_xtal(sys_clk_ctrl[`PMC_KEEP_XTAL_BIT]),
    .o_domains(domains),
    .o_allowed(allowed)
  );

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  function addr_mapped;
    input [7:0] addr;
    begin
      case (addr)
        `PMC_ADDR_POWER_DOWN,
        `PMC_ADDR_SYS_CLK,
        `PMC_ADDR_SLOW_CLK,
        `PMC_ADDR_IRQ_STATUS,
        `PMC_ADDR_IRQ_CLEAR,
        `PMC_ADDR_IRQ_ENABLE,
        `PMC_ADDR_MODE,
        `PMC_ADDR_STANDBY: addr_mapped = 1'b1;
        default: addr_mapped = 1'b0;
      endcase
    end
  endfunction

  wire setup_phase;
  wire access_done;
  wire wr_done;
  wire rd_done;

  assign setup_phase = i_psel && !i_penable;
  assign access_done = i_psel && i_penable && o_pready;
  assign wr_done = access_done && i_pwrite && addr_mapped(i_paddr);
  assign rd_done = access_done && !i_pwrite && addr_mapped(i_paddr);

  wire wr_power_down;
  wire wr_standby;
  wire rd_power_down;
  wire [2:0] pd_code;

  assign wr_power_down = wr_done && (i_paddr == `PMC_ADDR_POWER_DOWN);
  assign wr_standby = wr_done && (i_paddr == `PMC_ADDR_STANDBY) && i_pwdata[0];
  assign rd_power_down = rd_done && (i_paddr == `PMC_ADDR_POWER_DOWN);
  assign pd_code = i_pwdata[2:0];

  reg [31:0] read_mux;

  always @* begin
    read_mux = 32'h0000_0000;
    case (i_paddr)
      `PMC_ADDR_POWER_DOWN: read_mux = {24'h000000, wake_flags, 5'h00};
      `PMC_ADDR_SYS_CLK: read_mux = {24'h000000, sys_clk_ctrl};
      `PMC_ADDR_SLOW_CLK: read_mux = {24'h000000, 4'h0, xtal_running, slow_src};
      `PMC_ADDR_IRQ_STATUS: read_mux = {28'h0000000, irq_status};
      `PMC_ADDR_IRQ_ENABLE: read_mux = {28'h0000000, irq_enable};
      `PMC_ADDR_MODE: read_mux = {29'h00000000, state};
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // One wait-free access phase: ready comes from the setup cycle
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= setup_phase;
      o_pslverr <= setup_phase && !addr_mapped(i_paddr);
      if (setup_phase && !i_pwrite) begin
        o_prdata <= read_mux;
      end
    end
  end

  // ----------------------------------------
  // Clock control and interrupt-enable registers
  // ----------------------------------------
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      sys_clk_ctrl <= `PMC_SYS_CLK_RESET;
      slow_src <= `PMC_SLOW_CLK_RESET;
      irq_enable <= 4'h0;
    end else if (wr_done) begin
      if (i_paddr == `PMC_ADDR_SYS_CLK) begin
        sys_clk_ctrl <= i_pwdata[7:0];
      end
      if (i_paddr == `PMC_ADDR_SLOW_CLK) begin
        slow_src <= i_pwdata[2:0];
      end
      if (i_paddr == `PMC_ADDR_IRQ_ENABLE) begin
        irq_enable <= i_pwdata[3:0];
      end
    end
  end

  // ----------------------------------------
  // Mode entry and wake sequencing
  // ----------------------------------------
  wire asleep;
  wire [`PMC_WAKE_W-1:0] wake_hit;
  wire wake_now;
  wire slow_active;
  wire xtal_idle_cfg;
  wire use_short;

  assign asleep = (state != `PMC_ST_ACTIVE) && (state != `PMC_ST_WAKE);
  assign wake_hit = wake_vec & allowed;
  assign wake_now = asleep && (|wake_hit);
  assign slow_active = (slow_src <= `PMC_SLOW_LAST_ACTIVE);
  assign xtal_idle_cfg = (sys_clk_ctrl[`PMC_START_SEL_HI:`PMC_START_SEL_LO] == `PMC_START_RC_ONLY);
  assign use_short = (state == `PMC_ST_REG_ON) && wake_hit[`PMC_WAKE_TICK] &&
                     (xtal_idle_cfg || sys_clk_ctrl[`PMC_KEEP_XTAL_BIT]) && xtal_at_entry;

  wire enter_mode;

  assign enter_mode = (state == `PMC_ST_ACTIVE) && wr_power_down &&
                      (pd_code != `PMC_PD_NONE) && (pd_code <= `PMC_PD_REG);

  reg [2:0] next_state;

  always @* begin
    next_state = state;
    case (pd_code)
      `PMC_PD_DEEP: next_state = `PMC_ST_DEEP;
      `PMC_PD_MEM_OFF: next_state = `PMC_ST_MEM_OFF;
      `PMC_PD_MEM_ON: next_state = `PMC_ST_MEM_ON;
      `PMC_PD_REG: next_state = slow_active ? `PMC_ST_REG_ON : `PMC_ST_REG_OFF;
      default: next_state = state;
    endcase
  end

  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= `PMC_ST_ACTIVE;
      xtal_at_entry <= 1'b0;
      reset_on_wake <= 1'b0;
      wake_count <= {`PMC_CNT_W{1'b0}};
      o_cpu_resume <= 1'b0;
      o_system_reset <= 1'b0;
      o_short_prestart <= 1'b0;
    end else begin
      o_cpu_resume <= 1'b0;
      o_system_reset <= 1'b0;
      case (state)
        `PMC_ST_ACTIVE: begin
          if (enter_mode) begin
            state <= next_state;
            xtal_at_entry <= xtal_running;
          end else if (wr_standby) begin
            state <= `PMC_ST_STANDBY;
          end
        end
        `PMC_ST_DEEP,
        `PMC_ST_MEM_OFF,
        `PMC_ST_MEM_ON,
        `PMC_ST_REG_OFF,
        `PMC_ST_REG_ON,
        `PMC_ST_STANDBY: begin
          if (wake_now) begin
            state <= `PMC_ST_WAKE;
            reset_on_wake <= (state == `PMC_ST_DEEP) || (state == `PMC_ST_MEM_OFF) ||
                             (state == `PMC_ST_MEM_ON);
            o_short_prestart <= use_short;
            if (state == `PMC_ST_STANDBY) begin
              wake_count <= STANDBY_WAKE_CYCLES;
            end else if (use_short) begin
              wake_count <= SHORT_PRESTART_CYCLES;
            end else begin
              wake_count <= LONG_PRESTART_CYCLES;
            end
          end
        end
        `PMC_ST_WAKE: begin
          if (wake_count <= 16'h0001) begin
            state <= `PMC_ST_ACTIVE;
            o_system_reset <= reset_on_wake;
            o_cpu_resume <= !reset_on_wake;
            o_short_prestart <= 1'b0;
          end else begin
            wake_count <= wake_count - 16'h0001;
          end
        end
        default: begin
          state <= `PMC_ST_ACTIVE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Wake-cause flags and interrupt status
  // ----------------------------------------
  wire [2:0] flag_set;
  wire [3:0] irq_set;
  wire [3:0] irq_clr;

  assign flag_set = wake_now ? wake_hit[`PMC_WAKE_COMP:`PMC_WAKE_PIN] : 3'h0;
  assign irq_set = wake_now ? {wake_hit[`PMC_WAKE_MISC] | wake_hit[`PMC_WAKE_RADIO],
                               wake_hit[`PMC_WAKE_COMP:`PMC_WAKE_PIN]} : 4'h0;
  assign irq_clr = (wr_done && (i_paddr == `PMC_ADDR_IRQ_CLEAR)) ? i_pwdata[3:0] : 4'h0;

  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      wake_flags <= 3'h0;
      irq_status <= 4'h0;
    end else begin
      // Set wins over a same-cycle read or entry clear
      if (enter_mode || rd_power_down) begin
        wake_flags <= {flag_set[0], flag_set[1], flag_set[2]};
      end else begin
        wake_flags <= wake_flags | {flag_set[0], flag_set[1], flag_set[2]};
      end
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_domain_power <= 8'hFF;
      o_cpu_clock_en <= 1'b1;
      o_irq <= 1'b0;
    end else begin
      o_domain_power <= domains;
      o_cpu_clock_en <= (state == `PMC_ST_ACTIVE);
      o_irq <= |(irq_status & irq_enable);
    end
  end

endmodule

// ===== verif/power_mode_chk.sv
// Port checker for the power-mode controller.
// Assumes it is bound onto power_mode_controller, one clock domain.
`timescale 1ns/1ps
module power_mode_chk (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_psel,
  input wire i_penable,
  input wire o_pready,
  input wire o_pslverr,
  input wire [7:0] o_domain_power,
  input wire o_cpu_clock_en,
  input wire o_cpu_resume,
  input wire o_system_reset,
  input wire o_short_prestart
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  sequence setup_s;
    i_psel && !i_penable;
  endsequence
  sequence wake_end_s;
    o_cpu_resume || o_system_reset;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> o_pready) else $error("no ready after setup");
  ready_in_access_a: assert property (o_pready |-> i_psel && i_penable) else $error("stray ready");
  err_with_ready_a: assert property (o_pslverr |-> o_pready) else $error("error without ready");
  pulse_exclusive_a: assert property (!(o_cpu_resume && o_system_reset)) else $error("resume and reset");
  pulse_single_a: assert property (wake_end_s |=> !o_cpu_resume && !o_system_reset) else $error("long pulse");
  clock_after_wake_a: assert property ($rose(o_cpu_clock_en) |-> $past(o_cpu_resume) || $past(o_system_reset))
    else $error("clock without wake");
  wake_runs_a: assert property (wake_end_s |=> o_cpu_clock_en && o_domain_power == 8'hFF)
    else $error("not running after wake");
  active_powered_a: assert property (o_cpu_clock_en |-> o_domain_power == 8'hFF) else $error("active unpowered");
  short_then_resume_a: assert property ($rose(o_short_prestart) |-> !o_cpu_clock_en ##[1:8] o_cpu_resume)
    else $error("short start no resume");
  sleep_holds_a: assert property ($fell(o_cpu_clock_en) |-> !o_cpu_clock_en [*3]) else $error("sleep too short");
endmodule
bind power_mode_controller power_mode_chk power_mode_chk_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_domain_power(o_domain_power), .o_cpu_clock_en(o_cpu_clock_en), .o_cpu_resume(o_cpu_resume),
  .o_system_reset(o_system_reset), .o_short_prestart(o_short_prestart));

// ===== verif/wake_source_model.sv
// Wake sources and fast crystal seen from the controller.
// Assumes the bench fires a one-cycle request vector.
`timescale 1ns/1ps
module wake_source_model #(
  parameter HOLD = 4
) (
  input wire i_clock,
  input wire [4:0] i_fire,
  input wire i_xtal_on,
  output logic o_wake_pin,
  output logic o_wake_tick,
  output logic o_wake_comp,
  output logic o_radio_interrupt,
  output logic o_misc_interrupt,
  output logic o_fast_crystal_running
);
  int left = 0;
  logic [4:0] held = 5'h00;
  // Lines idle low between events, level held long enough to sync
  always @(posedge i_clock) begin
    if (i_fire != 5'h00) begin
      held <= i_fire;
      left <= HOLD;
    end else if (left > 0) begin
      left <= left - 1;
    end else begin
      held <= 5'h00;
    end
  end
  // Crystal reports running a cycle after start, never at once
  always @(posedge i_clock) begin
    o_fast_crystal_running <= i_xtal_on;
  end
  assign o_wake_pin = held[0];
  assign o_wake_tick = held[1];
  assign o_wake_comp = held[2];
  assign o_radio_interrupt = held[3];
  assign o_misc_interrupt = held[4];
endmodule

// ===== verif/tb_top.sv
// Bench: sleep and wake cycles of the controller against a bench model.
// Assumes the design header and the wake-source model.
`timescale 1ns/1ps
module tb_top;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, pin, tick, comp, radio, misc, xtal, e, xtal_on = 1'b0;
  logic [4:0] fire = 5'h00;
  logic [7:0] dom;
  logic cpu_en, resume, sys_rst, short_pre, irq;
  int n_fail = 0, checked = 0;
  power_mode_controller #(.LONG_PRESTART_CYCLES(16'h0010)) power_mode_controller_inst (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_wake_pin(pin), .i_wake_tick(tick), .i_wake_comp(comp), .i_radio_interrupt(radio),
    .i_misc_interrupt(misc), .i_fast_crystal_running(xtal), .o_domain_power(dom),
    .o_cpu_clock_en(cpu_en), .o_cpu_resume(resume), .o_system_reset(sys_rst),
    .o_short_prestart(short_pre), .o_irq(irq));
  wake_source_model wake_source_model_inst (.i_clock(i_clock), .i_fire(fire), .i_xtal_on(xtal_on),
    .o_wake_pin(pin), .o_wake_tick(tick), .o_wake_comp(comp), .o_radio_interrupt(radio),
    .o_misc_interrupt(misc), .o_fast_crystal_running(xtal));
  initial forever #2.5 i_clock = ~i_clock;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'($urandom()), d[7:0]};
    @(posedge i_clock);
    penable <= 1'b1;
    // No wait-state limit here; only the watchdog ends a hung transfer
    do begin
      @(posedge i_clock);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ----------------------------------------
  // Bench model of modes
  // ----------------------------------------
  function automatic logic [4:0] allowed_of(input int st);
    case (st)
      3, 5: return 5'h07;
      6: return 5'h1B;
      default: return 5'h01;
    endcase
  endfunction
  function automatic logic [7:0] dom_of(input int st, input logic keep);
    case (st)
      1: return 8'h01;
      2: return 8'h03;
      3: return 8'h07;
      4, 5: return {3'h0, keep, 4'hF};
      default: return 8'hFF;
    endcase
  endfunction
  task automatic sleep(input int code, input logic [2:0] slow, input logic [7:0] sclk, input logic xon,
      input logic [4:0] wake, input logic [3:0] ien);
    int st, n;
    logic saw, exp_short;
    logic [3:0] stat;
    n = 0;
    saw = 1'b0;
    xtal_on <= xon;
    apb(1'b1, 8'h04, 32'(sclk));
    apb(1'b1, 8'h08, 32'(slow));
    apb(1'b1, 8'h14, 32'(ien));
    st = (code == 6) ? 6 : (code == 4 && slow <= 3'h4) ? 5 : code;
    apb(1'b1, (code == 6) ? 8'h1C : 8'h00, (code == 6) ? 32'h1 : 32'(code));
    repeat (2) @(posedge i_clock);
    #1;
    chk("domains", 32'(dom), 32'(dom_of(st, sclk[7])));
    chk("cpu_clock", 32'(cpu_en), 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("mode", q, 32'(st));
    fire <= 5'($urandom()) & ~allowed_of(st);
    @(posedge i_clock);
    fire <= 5'h00;
    repeat (8) @(posedge i_clock);
    #1;
    chk("ignored", 32'(cpu_en), 32'h0);
    @(posedge i_clock);
    fire <= wake;
    @(posedge i_clock);
    fire <= 5'h00;
    while (resume !== 1'b1 && sys_rst !== 1'b1 && n < 200) begin
      @(posedge i_clock);
      #1;
      saw |= short_pre;
      n++;
    end
    exp_short = (st == 5) && wake[1] && (sclk[5:4] == 2'h1 || sclk[7]) && xon;
    chk("reset_pulse", 32'(sys_rst), 32'(st < 4));
    chk("resume_pulse", 32'(resume), 32'(st >= 4));
    chk("short", 32'(saw), 32'(exp_short));
    chk("wake_len", 32'(n > 12), 32'(!exp_short));
    apb(1'b0, 8'h00, 32'h0);
    chk("flags", q, 32'({wake[0], wake[1], wake[2], 5'h00}));
    apb(1'b0, 8'h00, 32'h0);
    chk("flags_clear", q, 32'h0);
    stat = {|wake[4:3], wake[2:0]};
    apb(1'b0, 8'h0C, 32'h0);
    chk("status", q, 32'(stat));
    chk("irq", 32'(irq), 32'(|(stat & ien)));
    apb(1'b1, 8'h10, 32'hF);
    repeat (2) @(posedge i_clock);
    #1;
    chk("irq_clear", 32'(irq), 32'h0);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    q = $urandom(32'h7EAF2CE2);
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clock);
    #1;
    chk("active_dom", 32'(dom), 32'hFF);
    chk("active_cpu", 32'(cpu_en), 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk("sys_clk_reset", q, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk("slow_clk_reset", q, 32'h7);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", {q[30:0], e}, 32'h1);
    apb(1'b1, 8'h00, 32'h5);
    apb(1'b0, 8'h18, 32'h0);
    chk("reserved_code", q, 32'h0);
    sleep(1, 3'h7, 8'h00, 1'b0, 5'h01, 4'h1);
    sleep(2, 3'h7, 8'h00, 1'b0, 5'h01, 4'h0);
    sleep(3, 3'h1, 8'h00, 1'b1, 5'h04, 4'h4);
    sleep(4, 3'h7, 8'h90, 1'b1, 5'h01, 4'h1);
    sleep(4, 3'h1, 8'h80, 1'b1, 5'h02, 4'h2);
    sleep(4, 3'h4, 8'h10, 1'b1, 5'h02, 4'h2);
    sleep(4, 3'h0, 8'h10, 1'b0, 5'h02, 4'h0);
    sleep(4, 3'h2, 8'h00, 1'b1, 5'h06, 4'h0);
    sleep(6, 3'h7, 8'h00, 1'b1, 5'h08, 4'h8);
    sleep(6, 3'h7, 8'h00, 1'b1, 5'h10, 4'h8);
    give_verdict();
  end
  // Cuts a hang well past the expected several hundred cycles
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
endmodule
